// [logic/stop_clk_defs.svh]
/*
 * Register offsets, field positions and reset values of the clock and
 * power control block. Assumes an 8-bit register port.
 */
`ifndef STOP_CLK_DEFS_SVH
`define STOP_CLK_DEFS_SVH
`define OFS_CLK_A 8'h00
`define OFS_CLK_B 8'h01
`define OFS_CLK_C 8'h02
`define OFS_PMODE 8'h03
`define OFS_PROT 8'h04
`define OFS_STAT 8'h05
`define BIT_WAIT_GATE 2
`define BIT_DIV8 6
`define BIT_STOP 0
`define BIT_AUX 1
`define BIT_DIV_LO 6
`define BIT_DIV_HI 7
`define BIT_DET_EN 0
`define BIT_SRC 1
`define BIT_DET_ACT 7
`define BIT_LOCK 1
`define BIT_UNLOCK 1
`define RST_CLK_A 8'h40
`define RST_ZERO 8'h00
`endif

// [logic/stop_clk_pkg.sv]
/*
 * Types of the clock and power control block.
 * Assumes nothing beyond the defs header.
 */
`default_nettype none
package stop_clk_pkg;
  typedef enum logic [1:0] {st_normal, st_wait, st_stop} power_e;
  // Clock selection that the divider actually runs with
  typedef struct packed {
    logic src;
    logic div8;
    logic [1:0] div;
  } clk_cfg_s;
endpackage : stop_clk_pkg
`default_nettype wire

// [logic/stop_clk_ctrl.sv]
/*
 * Stop and wait mode control, CPU clock source and divider selection,
 * clock lock and the (inert) oscillation stop detector.
 * Assumes oscillator ticks arrive on pins from outside the clk domain
 * and that wake and interrupt requests come from logic on clk.
 */
// Local design decisions: the plain strobed port and the address map.
`default_nettype none
`include "stop_clk_defs.svh"

module stop_clk_ctrl
  import stop_clk_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic main_osc_pin,
  input wire logic onchip_osc_pin,
  input wire logic wake_req,
  input wire logic periph_irq,
  input wire logic wait_exec,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic main_osc_on,
  output logic onchip_osc_on,
  output logic io_hold,
  output logic osc_detect_reset,
  output logic osc_detect_irq,
  output logic [1:0] power_state
);

  // Reset release through two flip-flops
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Oscillator pins: three flops, a level counts once stages 2 and 3 agree
  logic [1:0] pin_in;
  logic [1:0] level;
  logic [1:0] tick;
  assign pin_in = {onchip_osc_pin, main_osc_pin};
  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic [2:0] sync;
    logic lvl;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sync <= 3'b000;
        lvl <= 1'b0;
      end else begin
        sync <= {sync[1:0], pin_in[g]};
        lvl <= (sync[1] == sync[2]) ? sync[2] : lvl;
      end
    end
    assign level[g] = lvl;
    assign tick[g] = (sync[1] == sync[2]) & sync[2] & ~lvl;
  end

  // Division ratio minus one, used by the divider and its checks
  function automatic logic [3:0] div_last(input clk_cfg_s c);
    if (c.div8) begin
      div_last = 4'h7;
    end else begin
      unique case (c.div)
        2'b00: div_last = 4'h0;
        2'b01: div_last = 4'h1;
        2'b10: div_last = 4'h3;
        2'b11: div_last = 4'hf;
      endcase
    end
  endfunction : div_last

  // Register state
  logic wait_gate, div8, stop_bit, aux, det_en, src, det_act;
  logic lock, unlock;
  logic [1:0] div;
  logic next_wait_gate, next_div8, next_aux, next_det_en, next_src;
  logic next_det_act, next_lock, next_unlock;
  logic [1:0] next_div;
  power_e state, next_state;
  clk_cfg_s act, next_act, req;
  logic [3:0] cnt, next_cnt;
  logic [7:0] next_rdata;
  logic sel_tick, term, stop_go, wake_any;

  assign req = '{src: src, div8: div8, div: div};
  assign sel_tick = act.src ? tick[1] : tick[0];
  assign term = sel_tick & (cnt == div_last(act));
  assign stop_go = wr & (addr == `OFS_CLK_B) & wdata[`BIT_STOP] & ~lock &
                   (state == st_normal);
  assign wake_any = wake_req | (periph_irq & ~wait_gate);

  // Register writes; the lock only ever engages, reset clears it
  always_comb begin
    next_wait_gate = wait_gate;
    next_div8 = div8;
    next_div = div;
    next_aux = aux;
    next_det_en = det_en;
    next_src = src;
    next_det_act = det_act;
    next_lock = lock;
    next_unlock = unlock;
    if (wr) begin
      unique case (addr)
        `OFS_CLK_A: begin
          if (!lock) begin
            next_wait_gate = wdata[`BIT_WAIT_GATE];
          end
          next_div8 = wdata[`BIT_DIV8];
        end
        `OFS_CLK_B: begin
          if (!lock) begin
            next_aux = wdata[`BIT_AUX];
          end
          next_div = {wdata[`BIT_DIV_HI], wdata[`BIT_DIV_LO]};
        end
        `OFS_CLK_C: begin
          if (!lock) begin
            next_det_en = wdata[`BIT_DET_EN];
          end
          next_src = wdata[`BIT_SRC];
          next_det_act = wdata[`BIT_DET_ACT];
        end
        `OFS_PMODE: begin
          if (unlock) begin
            next_lock = lock | wdata[`BIT_LOCK];
          end
        end
        `OFS_PROT: next_unlock = wdata[`BIT_UNLOCK];
        default: ;
      endcase
    end
    if (stop_go) begin
      next_div8 = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_gate <= 1'b0;
      div8 <= 1'b1;
      div <= 2'b00;
      aux <= 1'b0;
      det_en <= 1'b0;
      src <= 1'b0;
      det_act <= 1'b0;
      lock <= 1'b0;
      unlock <= 1'b0;
    end else begin
      wait_gate <= next_wait_gate;
      div8 <= next_div8;
      div <= next_div;
      aux <= next_aux;
      det_en <= next_det_en;
      src <= next_src;
      det_act <= next_det_act;
      lock <= next_lock;
      unlock <= next_unlock;
    end
  end

  // Power mode; stop and wait only return to normal
  always_comb begin
    next_state = state;
    unique case (state)
      st_normal: begin
        if (stop_go) begin
          next_state = st_stop;
        end else if (wait_exec) begin
          next_state = st_wait;
        end
      end
      st_wait: if (wake_any) next_state = st_normal;
      st_stop: if (wake_req) next_state = st_normal;
      default: next_state = st_normal;
    endcase
  end

  // Divider: a new selection is taken only at the wrap or while in stop, so no short pulse
  always_comb begin
    next_cnt = cnt;
    next_act = act;
    if (state == st_stop) begin
      next_cnt = 4'h0;
      next_act = req;
    end else if (term) begin
      next_cnt = 4'h0;
      next_act = req;
    end else if (sel_tick) begin
      next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_normal;
      cnt <= 4'h0;
      act <= '{src: 1'b0, div8: 1'b1, div: 2'b00};
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      act <= next_act;
    end
  end

  // Clock enables follow the mode; the stop bit reads back as the mode
  assign stop_bit = (state == st_stop);
  assign cpu_clk_en = term & (state == st_normal);
  assign periph_clk_en = sel_tick & ~stop_bit &
                         ~((state == st_wait) & wait_gate);
  assign main_osc_on = ~stop_bit;
  assign onchip_osc_on = ~stop_bit;
  assign io_hold = stop_bit;
  assign power_state = state;
  // Detector is not built here, so both its outputs stay low even with det_en set
  assign osc_detect_reset = 1'b0;
  assign osc_detect_irq = 1'b0;

  // Read data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `OFS_CLK_A: begin
          next_rdata[`BIT_WAIT_GATE] = wait_gate;
          next_rdata[`BIT_DIV8] = div8;
        end
        `OFS_CLK_B: begin
          next_rdata[`BIT_STOP] = stop_bit;
          next_rdata[`BIT_AUX] = aux;
          next_rdata[`BIT_DIV_LO] = div[0];
          next_rdata[`BIT_DIV_HI] = div[1];
        end
        `OFS_CLK_C: begin
          next_rdata[`BIT_DET_EN] = det_en;
          next_rdata[`BIT_SRC] = src;
          next_rdata[`BIT_DET_ACT] = det_act;
        end
        `OFS_PMODE: next_rdata[`BIT_LOCK] = lock;
        `OFS_PROT: next_rdata[`BIT_UNLOCK] = unlock;
        `OFS_STAT: next_rdata = {3'b000, level, act.src, state};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_stop_enter;
    stop_go |=> stop_bit && div8;
  endproperty
  a_stop_enter: assert property (p_stop_enter)
    else $error("stop write did not enter stop");

  property p_div8_forced;
    $rose(stop_bit) |-> div8 ##1 act.div8;
  endproperty
  a_div8_forced: assert property (p_div8_forced)
    else $error("div8 not forced on stop entry");

  property p_stop_quiet;
    stop_bit |-> !cpu_clk_en && !periph_clk_en && !main_osc_on;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("clock running in stop");

  property p_stop_hold;
    stop_bit && !wake_req |=> stop_bit;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop left without wake");

  property p_wake;
    stop_bit && wake_req |=> state == st_normal && act.div8;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not resume at divide by 8");

  property p_src_kept;
    stop_bit ##1 !stop_bit |-> act.src == $past(src);
  endproperty
  a_src_kept: assert property (p_src_kept)
    else $error("source after stop differs");

  // Pins freeze for exactly the stop span, however short the stay is
  property p_io_hold;
    io_hold == (power_state == 2'd2);
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("pins not held in stop");

  property p_no_cross;
    stop_bit |=> state != st_wait;
  endproperty
  a_no_cross: assert property (p_no_cross)
    else $error("stop went straight to wait");

  property p_wait_enter;
    state == st_normal && wait_exec && !stop_go |=> state == st_wait;
  endproperty
  a_wait_enter: assert property (p_wait_enter)
    else $error("wait instruction ignored");

  property p_lock;
    lock && wr && addr == `OFS_CLK_C |=> $stable(det_en);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked bit was written");

  property p_detect;
    !osc_detect_reset && !osc_detect_irq;
  endproperty
  a_detect: assert property (p_detect)
    else $error("detector fired");

  property p_wait_gate;
    state == st_wait |-> !cpu_clk_en && !(wait_gate && periph_clk_en);
  endproperty
  a_wait_gate: assert property (p_wait_gate)
    else $error("clock not gated in wait");

  property p_glitch;
    act != $past(act) |-> $past(term) || $past(stop_bit);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("selection changed mid period");

  property p_src_pick;
    cpu_clk_en |-> (act.src ? tick[1] : tick[0]) &&
                   cnt == div_last(act);
  endproperty
  a_src_pick: assert property (p_src_pick)
    else $error("cpu clock from wrong source or count");

  c_stop: cover property (stop_go ##[1:20] !stop_bit);
  c_wait: cover property (state == st_wait ##[1:20] state == st_normal);
  c_switch: cover property ($rose(act.src));
  c_div16: cover property (cpu_clk_en && act.div == 2'b11 && !act.div8);

endmodule : stop_clk_ctrl
`default_nettype wire

// [sim/stop_mode_clock_power_control_bench.sv]
/*
 * Self-checking bench for the stop, wait and clock selection block.
 * Assumes the block's package, defs header and module are compiled first.
 */
`default_nettype none
module stop_mode_clock_power_control_bench
  import stop_clk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic main_osc_pin = 1'b0;
  logic onchip_osc_pin = 1'b0;
  logic wake_req = 1'b0;
  logic periph_irq = 1'b0;
  logic wait_exec = 1'b0;
  logic [7:0] rdata;
  logic cpu_clk_en, periph_clk_en, main_osc_on, onchip_osc_on, io_hold;
  logic osc_detect_reset, osc_detect_irq;
  logic [1:0] power_state;
  logic rd_q = 1'b0;
  logic [15:0] exp_q[$];
  logic [7:0] f;
  int err_total = 0;
  int checked = 0;
  integer seed = 58352;
  int ratio_tab [5] = '{1, 2, 4, 16, 8};

  stop_clk_ctrl DUT (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
    .main_osc_pin, .onchip_osc_pin, .wake_req, .periph_irq, .wait_exec,
    .cpu_clk_en, .periph_clk_en, .main_osc_on, .onchip_osc_on, .io_hold,
    .osc_detect_reset, .osc_detect_irq, .power_state);

  // Clock and two oscillators slow enough for the three-flop sync
  initial begin
    forever #2 clk = ~clk;
  end
  always begin
    repeat (3) @(posedge clk);
    main_osc_pin <= ~main_osc_pin;
  end
  always begin
    repeat (5) @(posedge clk);
    onchip_osc_pin <= ~onchip_osc_pin;
  end

  task automatic finish_test();
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data is compared later by the monitor, under a mask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // 0 wake, 1 peripheral interrupt, 2 wait instruction
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: wake_req <= 1'b1;
      1: periph_irq <= 1'b1;
      default: wait_exec <= 1'b1;
    endcase
    @(posedge clk);
    wake_req <= 1'b0;
    periph_irq <= 1'b0;
    wait_exec <= 1'b0;
  endtask : pulse

  task automatic st(input logic [1:0] s);
    #1;
    check({5'h00, io_hold, power_state}, {5'h00, s == 2'd2, s});
    check({6'h00, main_osc_on, onchip_osc_on},
          s == 2'd2 ? 8'h00 : 8'h03);
  endtask : st

  task automatic count(input int n, output int c, output int p);
    c = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      c += cpu_clk_en;
      p += periph_clk_en;
    end
  endtask : count

  // Start on a divider wrap so 32 source ticks hold 32/ratio pulses
  task automatic measure(input int r);
    int c, p, k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (cpu_clk_en !== 1'b1 && k < 500);
    c = 0;
    p = 0;
    while (p < 32 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
      c += cpu_clk_en;
      p += periph_clk_en;
    end
    check(8'(c), 8'(32 / r));
  endtask : measure

  // Monitor: read data one cycle after the strobe, detector always quiet
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    logic [15:0] n;
    if (rd_q) begin
      n = exp_q.pop_front();
      check(rdata & n[15:8], n[7:0]);
    end
    check({6'h00, osc_detect_reset, osc_detect_irq}, 8'h00);
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    int c, p;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h00, 8'hff, 8'h40);
    rd_reg(8'h01, 8'hff, 8'h00);
    rd_reg(8'h05, 8'h07, 8'h00);
    wr_reg(8'h07, 8'hff);
    rd_reg(8'h07, 8'hff, 8'h00);
    // Every source with every ratio
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h02, {6'h00, s[0], 1'b0});
      for (int k = 0; k < 5; k++) begin
        wr_reg(8'h00, k == 4 ? 8'h40 : 8'h00);
        wr_reg(8'h01, k == 4 ? 8'h00 : {k[1:0], 6'h00});
        measure(ratio_tab[k]);
        rd_reg(8'h05, 8'h07, {5'h00, s[0], 2'b00});
      end
    end
    // Stop with a random divider field; interrupts and wait ignored
    f = 8'($random(seed)) & 8'hc0;
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h01, f);
    wr_reg(8'h01, f | 8'h01);
    st(2'd2);
    pulse(1);
    pulse(2);
    st(2'd2);
    count(40, c, p);
    check(8'(c + p), 8'h00);
    rd_reg(8'h00, 8'hff, 8'h40);
    rd_reg(8'h01, 8'hff, f | 8'h01);
    pulse(0);
    st(2'd0);
    rd_reg(8'h01, 8'hff, f);
    measure(8);
    rd_reg(8'h05, 8'h07, 8'h04);
    // Wait mode, peripheral clocks free, then gated
    wr_reg(8'h00, 8'h40);
    pulse(2);
    st(2'd1);
    count(40, c, p);
    check(8'(c), 8'h00);
    check(8'(p != 0), 8'h01);
    pulse(1);
    st(2'd0);
    wr_reg(8'h00, 8'h44);
    pulse(2);
    pulse(1);
    st(2'd1);
    count(40, c, p);
    check(8'(c + p), 8'h00);
    pulse(0);
    st(2'd0);
    // Detector armed must stay silent; lock needs the unlock first
    wr_reg(8'h02, 8'h83);
    wr_reg(8'h01, 8'h02);
    count(40, c, p);
    wr_reg(8'h03, 8'h02);
    rd_reg(8'h03, 8'h02, 8'h00);
    wr_reg(8'h04, 8'h02);
    wr_reg(8'h03, 8'h02);
    wr_reg(8'h04, 8'h00);
    rd_reg(8'h03, 8'h02, 8'h02);
    // Locked: wait gate, aux and det_en keep their values and the stop write is refused; div8 and src still write
    wr_reg(8'h00, 8'h40);
    rd_reg(8'h00, 8'hff, 8'h44);
    wr_reg(8'h01, 8'h01);
    st(2'd0);
    rd_reg(8'h01, 8'hff, 8'h02);
    wr_reg(8'h02, 8'h00);
    rd_reg(8'h02, 8'hff, 8'h01);
    // Only a reset drops the lock
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h03, 8'h02, 8'h00);
    rd_reg(8'h00, 8'hff, 8'h40);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule : stop_mode_clock_power_control_bench
`default_nettype wire
